// [sim/lcj_exec_sva.sv]
`timescale 1ns/1ps
module lcj_exec_sva (
  // Watched ports
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  input wire logic [7:0] bank_data_in,
  input wire logic [7:0] direct_data_in,
  input wire logic ready_out,
  input wire logic illegal_out,
  input wire logic stack_we_out,
  input wire logic [7:0] stack_addr_out,
  input wire logic [7:0] stack_data_out,
  input wire logic [15:0] program_counter_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic [7:0] main_work_register_out
);
  logic cl;
  logic jp;
  logic md;
  logic [15:0] ret;
  logic [15:0] tgt;
  assign cl = start_in && ready_out && opcode_in == 8'h12;
  assign jp = start_in && ready_out && opcode_in == 8'h02;
  assign md = start_in && ready_out && opcode_in == 8'he5;
  assign ret = program_counter_out + 16'h0003;
  assign tgt = {byte2_in, byte3_in};
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  a_call_ready: assert property (cl |=> !ready_out ##1 ready_out)
    else $error("call length");
  a_call_low: assert property (cl |=> stack_we_out && stack_data_out == $past(ret[7:0])
    && stack_addr_out == $past(stack_pointer_out) + 8'h01) else $error("call low push");
  a_call_high: assert property (cl |-> ##2 stack_we_out
    && stack_addr_out == stack_pointer_out && stack_data_out == $past(ret[15:8], 2))
    else $error("call high push");
  a_call_sp: assert property (cl |-> ##2
    stack_pointer_out == $past(stack_pointer_out, 2) + 8'h02) else $error("call sp");
  a_call_target: assert property (cl |-> ##2 program_counter_out == $past(tgt, 2))
    else $error("call target");
  a_jump_load: assert property (jp |=> !stack_we_out ##1 !stack_we_out && ready_out
    && program_counter_out == $past(tgt, 2) && $stable(stack_pointer_out)) else $error("jump");
  a_bank_move: assert property (start_in && ready_out && opcode_in[7:3] == 5'h1d
    |=> main_work_register_out == $past(bank_data_in)) else $error("bank move");
  a_direct_move: assert property (md && byte2_in != 8'he0 |=>
    main_work_register_out == $past(direct_data_in)) else $error("direct move");
  a_self_move: assert property (md && byte2_in == 8'he0 |=> illegal_out
    && $stable(main_work_register_out)) else $error("self move");
  cover property (cl);
  cover property (jp);
  cover property (md && byte2_in == 8'he0);
endmodule : lcj_exec_sva
bind lcj_exec lcj_exec_sva chk_u (.*);

// [sim/lcj_mem_model.sv]
`timescale 1ns/1ps
module lcj_mem_model (
  // Clock
  input wire logic clock_in,
  // Stack write side
  input wire logic we_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  // Read side
  input wire logic [2:0] sel_in,
  input wire logic [7:0] dir_in,
  output logic [7:0] bank_out,
  output logic [7:0] dir_out
);
  logic [7:0] ram [256];
  always @(posedge clock_in) if (we_in) ram[addr_in] <= data_in;
  assign bank_out = {5'h15, sel_in};
  assign dir_out = ~dir_in;
endmodule : lcj_mem_model

// [sim/long_call_jump_move_exec_tb_top.sv]
`timescale 1ns/1ps
module long_call_jump_move_exec_tb_top;
  logic clock_in = 0;
  logic nrst_in = 0;
  logic st = 0;
  logic rdy, ill, we;
  logic [7:0] opc = 0, b2 = 0, b3 = 0, bd, dd, sa, sd, sp, acc, da;
  logic [2:0] bs;
  logic [15:0] pc;
  int miscompares = 0;
  int checked = 0;
  always #50 clock_in = ~clock_in;
  lcj_exec dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(st), .opcode_in(opc),
    .byte2_in(b2), .byte3_in(b3), .ready_out(rdy), .illegal_out(ill), .bank_data_in(bd),
    .direct_data_in(dd), .bank_sel_out(bs), .direct_addr_out(da), .stack_we_out(we),
    .stack_addr_out(sa), .stack_data_out(sd), .program_counter_out(pc),
    .stack_pointer_out(sp), .main_work_register_out(acc));
  lcj_mem_model mem_u (.clock_in(clock_in), .we_in(we), .addr_in(sa), .data_in(sd),
    .sel_in(bs), .dir_in(da), .bank_out(bd), .dir_out(dd));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic issue(input logic [7:0] o, input logic [7:0] x, input int n);
    @(negedge clock_in);
    st = 1;
    opc = o;
    b2 = x;
    b3 = 8'h34;
    @(negedge clock_in);
    st = 0;
    chk("ready", (n > 1) ? 16'h0000 : 16'h0001, {15'h0000, rdy});
    repeat (n - 1) @(negedge clock_in);
  endtask : issue
  task automatic test_call;
    issue(8'h02, 8'h01, 2);
    chk("pc", 16'h0134, pc);
    chk("sp", 16'h0007, {8'h00, sp});
    issue(8'h12, 8'h12, 2);
    chk("pc", 16'h1234, pc);
    chk("sp", 16'h0009, {8'h00, sp});
    @(negedge clock_in);
    chk("low", 16'h0037, {8'h00, mem_u.ram[8]});
    chk("high", 16'h0001, {8'h00, mem_u.ram[9]});
  endtask : test_call
  task automatic test_move;
    for (int i = 0; i < 8; i++) begin
      issue(8'he8 + 8'(i), 8'h00, 1);
      chk("acc", {8'h00, 5'h15, 3'(i)}, {8'h00, acc});
    end
    chk("pc", 16'h123c, pc);
    issue(8'he5, 8'h30, 1);
    chk("acc", 16'h00cf, {8'h00, acc});
    chk("pc", 16'h123e, pc);
    issue(8'he5, 8'he0, 1);
    chk("illegal", 16'h0001, {15'h0000, ill});
    chk("acc", 16'h00cf, {8'h00, acc});
    chk("pc", 16'h1240, pc);
    @(negedge clock_in);
    chk("illegal", 16'h0000, {15'h0000, ill});
    issue(8'h00, 8'h00, 1);
    chk("illegal", 16'h0001, {15'h0000, ill});
    chk("pc", 16'h1240, pc);
    chk("acc", 16'h00cf, {8'h00, acc});
    chk("sp", 16'h0009, {8'h00, sp});
  endtask : test_move
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(negedge clock_in);
    nrst_in = 1;
    test_call();
    test_move();
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : long_call_jump_move_exec_tb_top

// [src/lcj_decode.sv]
`timescale 1ns/1ps
module lcj_decode (
  // Opcode
  input wire logic [7:0] opcode_in,
  // Decoded class
  output lcj_pkg::lcj_kind_t kind_out,
  output logic is_direct_out,
  output logic [2:0] bank_sel_out
);
  always_comb begin
    kind_out = lcj_pkg::LCJ_KIND_NONE;
    is_direct_out = 1'b0;
    bank_sel_out = opcode_in[2:0];
    // [RQ1] Call opcode decode
    if (opcode_in == lcj_pkg::OP_LONG_SUBROUTINE_CALL_CODE) begin
      kind_out = lcj_pkg::LCJ_KIND_CALL;
    end
    // [RQ7] Jump opcode decode
    else if (opcode_in == lcj_pkg::OP_LJUMP_CODE) begin
      kind_out = lcj_pkg::LCJ_KIND_JUMP;
    end
    // [RQ10] Two move pairings
    // [RQ11] Move opcodes decode
    else if (opcode_in == lcj_pkg::OP_MOV_DIRECT) begin
      kind_out = lcj_pkg::LCJ_KIND_MOVE;
      is_direct_out = 1'b1;
    end else if (opcode_in[7:3] == lcj_pkg::OP_MOV_BANK_HI) begin
      kind_out = lcj_pkg::LCJ_KIND_MOVE;
    end
  end
endmodule : lcj_decode

// [src/lcj_exec.sv]
`timescale 1ns/1ps
// Operation
// [RQ1] Long call is opcode 0x12 plus two address bytes and takes two machine cycles.
// [RQ2] The return address is the call's own address plus three.
// [RQ3] The return address is pushed low byte first, then high byte.
// [RQ4] The stack pointer is incremented before each push, ending two higher.
// [RQ5] After the push the program counter takes byte two as high and byte three as low.
// [RQ6] The call reaches any 16-bit address and alters no flags.
// [RQ7] Long jump loads the program counter from bytes two and three of its three.
// [RQ8] Long jump pushes nothing, keeps the stack pointer and flags, takes two cycles.
// [RQ9] A byte move copies the source to the destination and touches nothing else.
// [RQ10] The byte-move family has fifteen addressing pairings, two of them handled here.
// [RQ11] Bank register to accumulator is 11101rrr, direct is 0xe5 plus address, one cycle.
// [RQ12] A direct move naming the accumulator itself leaves the accumulator undefined.
// [RQ13] Stack writes go to internal RAM at the incremented pointer, wrapping in 8 bits.
module lcj_exec (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Instruction issue
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  output logic ready_out,
  output logic illegal_out,
  // Bank register and direct read data
  input wire logic [7:0] bank_data_in,
  input wire logic [7:0] direct_data_in,
  output logic [2:0] bank_sel_out,
  output logic [7:0] direct_addr_out,
  // Stack write port
  output logic stack_we_out,
  output logic [7:0] stack_addr_out,
  output logic [7:0] stack_data_out,
  // Architectural state
  output logic [15:0] program_counter_out,
  output logic [7:0] stack_pointer_out,
  output logic [7:0] main_work_register_out
);
  typedef enum logic [1:0] {
    LCJ_IDLE,
    LCJ_CALL2,
    LCJ_JUMP2
  } lcj_state_t;

  lcj_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] acc_q, acc_d;
  logic [15:0] ret_q, ret_d;
  logic [15:0] target_q, target_d;
  logic we_q, we_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic ill_q, ill_d;
  lcj_pkg::lcj_kind_t kind;
  logic is_direct;
  logic [2:0] bank_sel;

  function automatic logic [15:0] lcj_addr16(input logic [7:0] hi, input logic [7:0] lo);
    lcj_addr16 = {hi, lo};
  endfunction : lcj_addr16

  lcj_decode u_decode (
    .opcode_in(opcode_in),
    .kind_out(kind),
    .is_direct_out(is_direct),
    .bank_sel_out(bank_sel)
  );

  assign ready_out = (state_q == LCJ_IDLE);
  assign bank_sel_out = bank_sel;
  assign direct_addr_out = byte2_in;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = sp_q;
    acc_d = acc_q;
    ret_d = ret_q;
    target_d = target_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    ill_d = 1'b0;
    case (state_q)
      LCJ_IDLE: begin
        if (start_in) begin
          case (kind)
            lcj_pkg::LCJ_KIND_CALL: begin
              // [RQ2] Return address plus three
              ret_d = pc_q + lcj_pkg::CALL_LENGTH;
              // [RQ6] Full 16-bit target
              target_d = lcj_addr16(byte2_in, byte3_in);
              // [RQ4] First pre-increment
              sp_d = sp_q + 8'h01;
              // [RQ3] Low byte pushed first
              we_d = 1'b1;
              // [RQ13] Push at incremented pointer
              waddr_d = sp_q + 8'h01;
              wdata_d = ret_d[7:0];
              state_d = LCJ_CALL2;
            end
            lcj_pkg::LCJ_KIND_JUMP: begin
              // [RQ7] Jump target from bytes
              target_d = lcj_addr16(byte2_in, byte3_in);
              // [RQ8] Second cycle, no push
              state_d = LCJ_JUMP2;
            end
            lcj_pkg::LCJ_KIND_MOVE: begin
              // [RQ9] Copy source to accumulator
              if (is_direct) begin
                // [RQ12] Self-move flagged illegal, accumulator kept
                if (byte2_in == lcj_pkg::ACC_DIRECT_ADDR) begin
                  ill_d = 1'b1;
                end else begin
                  acc_d = direct_data_in;
                end
                // [RQ11] Direct form, two bytes
                pc_d = pc_q + lcj_pkg::DIRECT_LENGTH;
              end else begin
                // [RQ11] Bank form, one byte
                acc_d = bank_data_in;
                pc_d = pc_q + lcj_pkg::BANK_LENGTH;
              end
            end
            default: begin
              ill_d = 1'b1;
            end
          endcase
        end
      end
      LCJ_CALL2: begin
        // [RQ4] Second pre-increment
        sp_d = sp_q + 8'h01;
        // [RQ3] High byte pushed second
        we_d = 1'b1;
        waddr_d = sp_q + 8'h01;
        wdata_d = ret_q[15:8];
        // [RQ5] Load call target
        pc_d = target_q;
        state_d = LCJ_IDLE;
      end
      LCJ_JUMP2: begin
        // [RQ7] Load jump target
        pc_d = target_q;
        state_d = LCJ_IDLE;
      end
      default: begin
        state_d = LCJ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= LCJ_IDLE;
      pc_q <= lcj_pkg::PC_RESET;
      sp_q <= lcj_pkg::SP_RESET;
      acc_q <= lcj_pkg::ACC_RESET;
      ret_q <= 16'h0000;
      target_q <= 16'h0000;
      we_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      ill_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      acc_q <= acc_d;
      ret_q <= ret_d;
      target_q <= target_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      ill_q <= ill_d;
    end
  end

  assign stack_we_out = we_q;
  assign stack_addr_out = waddr_q;
  assign stack_data_out = wdata_q;
  assign illegal_out = ill_q;
  assign program_counter_out = pc_q;
  assign stack_pointer_out = sp_q;
  assign main_work_register_out = acc_q;
endmodule : lcj_exec

// [src/lcj_pkg.sv]
package lcj_pkg;
  // Opcodes
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL_CODE = 8'h12;
  localparam logic [7:0] OP_LJUMP_CODE = 8'h02;
  localparam logic [7:0] OP_MOV_DIRECT = 8'he5;
  localparam logic [4:0] OP_MOV_BANK_HI = 5'h1d;
  // Instruction geometry
  localparam logic [15:0] CALL_LENGTH = 16'h0003;
  localparam logic [15:0] JUMP_LENGTH = 16'h0003;
  localparam logic [15:0] DIRECT_LENGTH = 16'h0002;
  localparam logic [15:0] BANK_LENGTH = 16'h0001;
  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;
  // Direct address of the main work register
  localparam logic [7:0] ACC_DIRECT_ADDR = 8'he0;
  // Machine cycle figures
  localparam int CALL_CYCLES = 2;
  localparam int JUMP_CYCLES = 2;
  localparam int MOVE_CYCLES = 1;
  typedef enum logic [1:0] {
    LCJ_KIND_NONE,
    LCJ_KIND_CALL,
    LCJ_KIND_JUMP,
    LCJ_KIND_MOVE
  } lcj_kind_t;
endpackage : lcj_pkg
